// ===== rtl/gpt_defs.svh
// gpt_defs.svh: offsets, field positions, reset values and codes of the timer
// assumes a 6-bit byte address from the register port, one 16-bit word per 32-bit slot
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH
`define GPT_OFS_CTRL1 6'h00
`define GPT_OFS_CTRL2 6'h04
`define GPT_OFS_SMODE 6'h08
`define GPT_OFS_IEN 6'h0C
`define GPT_OFS_STAT 6'h10
`define GPT_OFS_EVGEN 6'h14
`define GPT_OFS_CCM1 6'h18
`define GPT_OFS_CCEN 6'h20
`define GPT_OFS_CNT 6'h24
`define GPT_OFS_PRESC 6'h28
`define GPT_OFS_RELOAD 6'h2C
`define GPT_OFS_CC1 6'h34
`define GPT_OFS_CC2 6'h38
// spacing of the compare slots
`define GPT_CC_STRIDE 6'h04
// control one field positions
`define GPT_B_RUN 0
`define GPT_B_UPD_DIS 1
`define GPT_B_URS 2
`define GPT_B_SPM 3
`define GPT_B_PRELOAD 7
`define GPT_B_DIV_LO 8
`define GPT_B_DIV_HI 9
// writable bits of control one
`define GPT_CTRL1_MASK 16'h038F
// bit 0 of status, event generate and irq enable
`define GPT_B_UPDATE 0
// slave mode field and its trigger code
`define GPT_SMODE_HI 2
`define GPT_SMODE_TRIGGER 3'h6
// divider codes
`define GPT_DIV_1 2'h0
`define GPT_DIV_2 2'h1
`define GPT_DIV_4 2'h2
// last phase of a divide-by-four period
`define GPT_DIV4_LAST 2'h3
// reset values
`define GPT_ZERO16 16'h0000
`define GPT_ONE16 16'h0001
`define GPT_RELOAD_RST 16'hFFFF
`define GPT_DIV_ONE 3'h1
`endif

// ===== rtl/gpt_pkg.sv
// gpt_pkg: types shared by the timer and its bench
// assumes gpt_defs.svh is on the include path
package gpt_pkg;
   // one register port request
   typedef struct packed {
      logic [5:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } gpt_bus_s;
   // hardware event inputs from the slave mode controller side
   typedef struct packed {
      logic trigger;
      logic slave_update;
   } gpt_evt_s;
   // divider setting as decoded
   typedef enum logic [1:0] {
      GPT_DIV1 = 2'b00,
      GPT_DIV2 = 2'b01,
      GPT_DIV4 = 2'b10,
      GPT_DIVR = 2'b11
   } gpt_div_e;
endpackage

// ===== rtl/gpt_timer.sv
// gpt_timer: control register one, register map and up-counting core of a 16-bit timer
// assumes synchronous strobes, one-cycle read latency, single 250 MHz clock
// trigger and slave update inputs come from slave mode logic outside this block
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "gpt_defs.svh"
module gpt_timer #(
   parameter int CH_NUM = 2
) (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire gpt_pkg::gpt_bus_s bus_in,
   input wire gpt_pkg::gpt_evt_s evt_in,
   output logic [15:0] rdata_out,
   output logic irq_out,
   output logic update_event_out,
   output logic sample_tick_out,
   output logic [15:0] count_out
);
   import gpt_pkg::*;

   // control and plain storage registers
   logic [15:0] ctrl1_r; // control one, only writable bits held
   logic [15:0] ctrl2_r; // control two, stored only
   logic [15:0] smode_r; // slave mode control
   logic [15:0] ien_r; // irq enable, doubles as the mask
   logic [15:0] stat_r; // sticky status
   logic [15:0] ccm1_r; // channel mode, stored only
   logic [15:0] ccen_r; // channel enable, stored only
   logic [15:0] cnt_r; // counter
   // prescaler and reload each keep a buffer beside the copy in use
   logic [15:0] pre_buf_r; // prescaler as written
   logic [15:0] pre_act_r; // prescaler in use
   logic [15:0] pre_cnt_r; // prescaler counter
   logic [15:0] rld_buf_r; // reload as written
   logic [15:0] rld_act_r; // reload latched at update
   logic [15:0] rdata_r; // read data register
   // registered outputs and the sample divider
   logic irq_r; // interrupt level
   logic upd_evt_r; // update pulse
   logic smp_r; // sample tick
   logic [2:0] smp_cnt_r; // divider phase counter

   // decoded strobes
   logic wr_ctrl1, wr_stat, wr_evgen, wr_cnt, wr_pre, wr_rld;
   logic run, upd_dis, urs, spm, preload;
   gpt_div_e div;
   logic trig_mode; // slave mode says trigger
   // update path terms
   logic pre_tick; // prescaler wrap
   logic ovf; // counter overflow on this cycle
   logic sw_upd; // software update generate
   logic upd_req; // any update source
   logic upd_evt; // update event after gating
   logic flag_set; // update flag request
   logic [15:0] rld_use; // reload seen by the counter
   logic [15:0] cc_rd [CH_NUM]; // buffered compare for readback

   // write strobes decoded per register
   // one write per cycle, so at most one strobe is high
   assign wr_ctrl1 = bus_in.wr && (bus_in.addr == `GPT_OFS_CTRL1);
   assign wr_stat = bus_in.wr && (bus_in.addr == `GPT_OFS_STAT);
   assign wr_evgen = bus_in.wr && (bus_in.addr == `GPT_OFS_EVGEN);
   assign wr_cnt = bus_in.wr && (bus_in.addr == `GPT_OFS_CNT);
   assign wr_pre = bus_in.wr && (bus_in.addr == `GPT_OFS_PRESC);
   assign wr_rld = bus_in.wr && (bus_in.addr == `GPT_OFS_RELOAD);

   // control one fields
   assign run = ctrl1_r[`GPT_B_RUN];
   assign upd_dis = ctrl1_r[`GPT_B_UPD_DIS];
   assign urs = ctrl1_r[`GPT_B_URS];
   assign spm = ctrl1_r[`GPT_B_SPM];
   assign preload = ctrl1_r[`GPT_B_PRELOAD];
   assign div = gpt_div_e'(ctrl1_r[`GPT_B_DIV_HI:`GPT_B_DIV_LO]);
   assign trig_mode = (smode_r[`GPT_SMODE_HI:0] == `GPT_SMODE_TRIGGER);

   assign rld_use = preload ? rld_act_r : rld_buf_r;

   // prescaler wraps after its setting plus one clocks
   // a setting of zero ticks every clock, so the ratio spans 1 to 65536
   assign pre_tick = run && (pre_cnt_r == pre_act_r);
   // overflow only on a counting tick, so a stopped counter never wraps
   assign ovf = pre_tick && (cnt_r == rld_use);
   assign sw_upd = wr_evgen && bus_in.wdata[`GPT_B_UPDATE];

   // update sources
   // the slave request is taken as a one-cycle pulse; a held level repeats it
   assign upd_req = ovf || sw_upd || evt_in.slave_update;
   // disable gates every source
   // the counter still wraps at reload while updates are disabled
   assign upd_evt = upd_req && !upd_dis;

   // every source flags when select is 0
   // only overflow flags when select is 1
   // software can thus load the shadows silently with select set
   assign flag_set = upd_evt && (!urs || ovf);

   // control one: software write, hardware set on trigger, clear on single pulse
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl1_r <= `GPT_ZERO16;
      end else begin
         if (wr_ctrl1) begin
            ctrl1_r <= bus_in.wdata & `GPT_CTRL1_MASK;
         end
         if (trig_mode && evt_in.trigger) begin
            ctrl1_r[`GPT_B_RUN] <= 1'b1;
         end
         // hardware set and clear follow the software write, so they win
         // the clear comes last, so single pulse beats a trigger in the same cycle
         if (upd_evt && spm) begin
            ctrl1_r[`GPT_B_RUN] <= 1'b0;
         end
      end
   end

   // registers written by software only; slave mode and irq enable are used, the rest only stored
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl2_r <= `GPT_ZERO16;
         smode_r <= `GPT_ZERO16;
         ien_r <= `GPT_ZERO16;
         ccm1_r <= `GPT_ZERO16;
         ccen_r <= `GPT_ZERO16;
      end else if (bus_in.wr) begin
         case (bus_in.addr)
            `GPT_OFS_CTRL2: begin
               ctrl2_r <= bus_in.wdata;
            end
            `GPT_OFS_SMODE: begin
               smode_r <= bus_in.wdata;
            end
            `GPT_OFS_IEN: begin
               ien_r <= bus_in.wdata;
            end
            `GPT_OFS_CCM1: begin
               ccm1_r <= bus_in.wdata;
            end
            `GPT_OFS_CCEN: begin
               ccen_r <= bus_in.wdata;
            end
            default: begin
               // other offsets handled elsewhere
            end
         endcase
      end
   end

   // status: write one to clear, a set in the same cycle wins
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stat_r <= `GPT_ZERO16;
      end else begin
         if (wr_stat) begin
            stat_r <= stat_r & ~bus_in.wdata;
         end
         if (flag_set) begin
            stat_r[`GPT_B_UPDATE] <= 1'b1;
         end
      end
   end

   // prescaler buffer and active copy
   // the ratio in use changes only at an update, so a write never cuts a period short
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         // both copies reset to zero, a ratio of one
         pre_buf_r <= `GPT_ZERO16;
         pre_act_r <= `GPT_ZERO16;
      end else begin
         // software always writes the buffer
         if (wr_pre) begin
            pre_buf_r <= bus_in.wdata;
         end
         if (upd_evt) begin
            pre_act_r <= pre_buf_r;
         end
      end
   end

   // prescaler counter, restarted by update so a new ratio starts clean
   // it holds its phase while stopped, so a restart resumes mid-period
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pre_cnt_r <= `GPT_ZERO16;
      end else if (upd_evt || pre_tick) begin
         // wrap on its own tick or on any update
         pre_cnt_r <= `GPT_ZERO16;
      end else if (run) begin
         // count clocks only while run is set
         pre_cnt_r <= pre_cnt_r + `GPT_ONE16;
      end
   end

   // reload buffer and the copy used while preload is on
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rld_buf_r <= `GPT_RELOAD_RST;
         rld_act_r <= `GPT_RELOAD_RST;
      end else begin
         if (wr_rld) begin
            rld_buf_r <= bus_in.wdata;
         end
         // with preload off the counter compares against the buffer instead
         if (upd_evt) begin
            rld_act_r <= rld_buf_r;
         end
      end
   end

   // counter: up-counting, wraps at reload, cleared by a forced update
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r <= `GPT_ZERO16;
      end else if (wr_cnt) begin
         // a software write beats a tick or an update in the same cycle
         cnt_r <= bus_in.wdata;
      end else if (ovf || upd_evt) begin
         // software or slave update restarts the count as an overflow would
         // an overflow clears the count even while updates are disabled
         cnt_r <= `GPT_ZERO16;
      end else if (pre_tick) begin
         // counts only while run is set
         cnt_r <= cnt_r + `GPT_ONE16;
      end
   end

   // per-channel compare buffer and active value
   genvar g;
   generate
      for (g = 0; g < CH_NUM; g++) begin : g_ch
         logic [15:0] cc_buf_r;
         logic [15:0] cc_act_r; // value the channel logic would compare
         logic wr_cc;
         // each channel owns one 32-bit slot, channel 0 at the first compare and the next one slot higher
         assign wr_cc = bus_in.wr &&
            (bus_in.addr == (`GPT_OFS_CC1 + (6'(g) * `GPT_CC_STRIDE)));
         always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               cc_buf_r <= `GPT_ZERO16;
               cc_act_r <= `GPT_ZERO16;
            end else begin
               if (wr_cc) begin
                  cc_buf_r <= bus_in.wdata;
               end
               if (upd_evt) begin
                  cc_act_r <= cc_buf_r;
               end
            end
         end
         assign cc_rd[g] = cc_buf_r;
      end
   endgenerate

   // dead-time and filter sample tick
   // the phase counter runs free, so a divider change may shorten the first period
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         smp_cnt_r <= `GPT_DIV_ONE;
         smp_r <= 1'b0;
      end else begin
         // divide by 1, 2 or 4
         case (div)
            GPT_DIV2: begin
               // every second clock
               smp_r <= smp_cnt_r[0];
            end
            GPT_DIV4: begin
               // every fourth clock
               smp_r <= (smp_cnt_r[1:0] == `GPT_DIV4_LAST);
            end
            default: begin
               // reserved code behaves as divide by one
               // code 00 and the reserved code both tick every clock
               smp_r <= 1'b1;
            end
         endcase
         smp_cnt_r <= smp_cnt_r + `GPT_DIV_ONE;
      end
   end

   // update event pulse and interrupt level, both registered
   // registering both keeps the outputs free of decode glitches at one cycle of lag
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         upd_evt_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         // one pulse per gated update event
         upd_evt_r <= upd_evt;
         // a flag set this cycle raises irq one cycle after the status bit
         irq_r <= |(stat_r & ien_r);
      end
   end

   // read data, valid the cycle after the read strobe only
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_r <= `GPT_ZERO16;
      end else if (!bus_in.rd) begin
         rdata_r <= `GPT_ZERO16;
      end else begin
         case (bus_in.addr)
            `GPT_OFS_CTRL1: begin
               rdata_r <= ctrl1_r & `GPT_CTRL1_MASK;
            end
            `GPT_OFS_CTRL2: begin
               rdata_r <= ctrl2_r;
            end
            `GPT_OFS_SMODE: begin
               rdata_r <= smode_r;
            end
            `GPT_OFS_IEN: begin
               rdata_r <= ien_r;
            end
            `GPT_OFS_STAT: begin
               rdata_r <= stat_r;
            end
            `GPT_OFS_CCM1: begin
               rdata_r <= ccm1_r;
            end
            `GPT_OFS_CCEN: begin
               rdata_r <= ccen_r;
            end
            `GPT_OFS_CNT: begin
               rdata_r <= cnt_r;
            end
            `GPT_OFS_PRESC: begin
               // the buffer reads back, not the ratio in use
               rdata_r <= pre_buf_r;
            end
            `GPT_OFS_RELOAD: begin
               rdata_r <= rld_buf_r;
            end
            `GPT_OFS_CC1: begin
               rdata_r <= cc_rd[0];
            end
            `GPT_OFS_CC2: begin
               rdata_r <= cc_rd[CH_NUM-1];
            end
            default: begin
               // event generate is write only; unmapped reads give zero
               rdata_r <= `GPT_ZERO16;
            end
         endcase
      end
   end

   // counter view for the channel logic outside
   logic [15:0] cnt_out_r;
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_out_r <= `GPT_ZERO16;
      end else begin
         cnt_out_r <= cnt_r;
      end
   end

   // every output is a plain copy of a flip-flop
   // count_out lags the counter by one clock
   assign rdata_out = rdata_r;
   assign irq_out = irq_r;
   assign update_event_out = upd_evt_r;
   assign sample_tick_out = smp_r;
   assign count_out = cnt_out_r;
endmodule

// ===== verification/gpt_timer_asserts.sv
// gpt_timer_asserts: port-level checks of control one, the register map and update path
// assumes the gpt_timer ports and the offsets of gpt_defs.svh
`timescale 1ns/1ns
`include "gpt_defs.svh"
module gpt_timer_asserts (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire gpt_pkg::gpt_bus_s bus_in,
   input wire gpt_pkg::gpt_evt_s evt_in,
   input wire logic [15:0] rdata_out,
   input wire logic irq_out,
   input wire logic update_event_out,
   input wire logic sample_tick_out,
   input wire logic [15:0] count_out
);
   import gpt_pkg::*;
   logic dis_r; // shadow of update disable
   logic ien_r; // shadow of the update irq mask
   logic [1:0] div_r; // shadow of the divider code
   logic [2:0] age_r; // cycles since the divider changed, saturating
   logic wr_c1; // write to control one
   assign wr_c1 = bus_in.wr && bus_in.addr == `GPT_OFS_CTRL1;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   // shadows follow software only; hardware never moves these bits
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dis_r <= 1'b0;
         ien_r <= 1'b0;
         div_r <= 2'h0;
         age_r <= 3'h0;
      end else begin
         if (wr_c1) begin
            dis_r <= bus_in.wdata[1];
            div_r <= bus_in.wdata[9:8];
         end
         if (bus_in.wr && bus_in.addr == `GPT_OFS_IEN) begin
            ien_r <= bus_in.wdata[0];
         end
         // the tick phase may wander after a change, so give it time
         if (wr_c1 && bus_in.wdata[9:8] != div_r) begin
            age_r <= 3'h0;
         end else if (age_r != 3'h7) begin
            age_r <= age_r + 3'h1;
         end
      end
   end
   chk_rd_idle_zero: assert property (!$past(bus_in.rd) |-> rdata_out == 16'h0000) else $error("read data not zero");
   chk_ctrl1_reserved: assert property (bus_in.rd && bus_in.addr == `GPT_OFS_CTRL1 |=>
      (rdata_out & 16'hFC70) == 16'h0000) else $error("reserved control bits set");
   chk_unmapped_zero: assert property (bus_in.rd && bus_in.addr inside {6'h14, 6'h1C, 6'h30, 6'h3C} |=>
      rdata_out == 16'h0000) else $error("unmapped read not zero");
   chk_sw_update: assert property (bus_in.wr && bus_in.addr == `GPT_OFS_EVGEN && bus_in.wdata[0] && !dis_r |=>
      update_event_out) else $error("software update missing");
   chk_slave_update: assert property (evt_in.slave_update && !dis_r |=> update_event_out) else $error("slave update missing");
   chk_disable_gate: assert property ($past(dis_r) |-> !update_event_out) else $error("update while disabled");
   chk_irq_masked: assert property (irq_out |-> $past(ien_r)) else $error("irq while masked");
   chk_count_load: assert property (bus_in.wr && bus_in.addr == `GPT_OFS_CNT |->
      ##2 count_out == $past(bus_in.wdata, 2)) else $error("counter write lost");
   chk_count_frozen: assert property (wr_c1 && !bus_in.wdata[0] ##1
      (!bus_in.wr && !evt_in.trigger && !evt_in.slave_update)[*3] |=> $stable(count_out))
      else $error("counter moved while stopped");
   chk_div_one: assert property ((div_r == 2'h0 || div_r == 2'h3) && age_r > 3'h3 |-> sample_tick_out)
      else $error("tick missing at divide by one");
   chk_div_two: assert property (div_r == 2'h1 && age_r > 3'h4 |-> sample_tick_out != $past(sample_tick_out))
      else $error("tick not alternating");
endmodule
bind gpt_timer gpt_timer_asserts chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .bus_in(bus_in), .evt_in(evt_in),
   .rdata_out(rdata_out), .irq_out(irq_out), .update_event_out(update_event_out), .sample_tick_out(sample_tick_out),
   .count_out(count_out));

// ===== verification/gpt_timer_tb.sv
// gpt_timer_tb: directed register-port tests of control one and the update path
// assumes gpt_timer, gpt_pkg and gpt_defs.svh; the checker binds itself
`timescale 1ns/1ns
`include "gpt_defs.svh"
module gpt_timer_tb;
   import gpt_pkg::*;
   logic ref_clk_in = 1'b0; // 250 MHz clock
   logic rst_b_in = 1'b0; // active low reset
   gpt_bus_s bus = '0; // register port request
   gpt_evt_s evt = '0; // hardware event inputs
   logic [15:0] rdata_out; // read data
   logic [15:0] count_out; // counter copy
   logic irq_out; // interrupt level
   logic update_event_out; // update pulse
   logic sample_tick_out; // sample clock tick
   logic [15:0] rv; // last read value
   int failures = 0;
   int checks_done = 0;
   int n; // pulse tally
   int dexp[4] = '{16, 8, 4, 16}; // ticks in 16 clocks per divider code
   always #2 ref_clk_in = ~ref_clk_in;
   gpt_timer dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .bus_in(bus), .evt_in(evt), .rdata_out(rdata_out),
      .irq_out(irq_out), .update_event_out(update_event_out), .sample_tick_out(sample_tick_out), .count_out(count_out));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one-cycle write strobe; the next call waits an edge, so no double drive
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge ref_clk_in);
      bus.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [5:0] a);
      @(posedge ref_clk_in);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge ref_clk_in);
      bus.rd <= 1'b0;
      #1;
      rv = rdata_out;
   endtask
   // count update pulses (sel 0) or divider ticks (sel 1)
   task automatic tally(input int cyc, input int sel);
      n = 0;
      repeat (cyc) begin
         @(posedge ref_clk_in);
         #1;
         if ((sel == 0) ? update_event_out === 1'b1 : sample_tick_out === 1'b1) n++;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      rd(`GPT_OFS_CTRL1);
      check(rv, 16'h0000);
      rd(`GPT_OFS_RELOAD);
      check(rv, 16'hFFFF);
      rd(`GPT_OFS_PRESC);
      check(rv, 16'h0000);
      wr(`GPT_OFS_CTRL1, 16'hFC70);
      rd(`GPT_OFS_CTRL1);
      check(rv, 16'h0000);
      rd(6'h1C);
      check(rv, 16'h0000);
      wr(`GPT_OFS_CC2, 16'hA5C3);
      rd(`GPT_OFS_CC2);
      check(rv, 16'hA5C3);
      $display("test map done");
      // free run, reload 3 without preload: period of four clocks
      wr(`GPT_OFS_RELOAD, 16'h0003);
      wr(`GPT_OFS_CNT, 16'h0000);
      wr(`GPT_OFS_CTRL1, 16'h0001);
      tally(16, 0);
      check(16'(n), 16'h0004);
      wr(`GPT_OFS_CTRL1, 16'h0000);
      repeat (3) @(posedge ref_clk_in);
      rd(`GPT_OFS_CNT);
      n = rv;
      repeat (8) @(posedge ref_clk_in);
      rd(`GPT_OFS_CNT);
      check(rv, 16'(n));
      // prescaler 3 stretches each count to four clocks
      wr(`GPT_OFS_PRESC, 16'h0003);
      wr(`GPT_OFS_EVGEN, 16'h0001);
      wr(`GPT_OFS_CTRL1, 16'h0001);
      tally(32, 0);
      check(16'(n), 16'h0002);
      $display("test count done");
      // preload on: reload 1 waits for the next overflow
      wr(`GPT_OFS_PRESC, 16'h0000);
      wr(`GPT_OFS_EVGEN, 16'h0001);
      wr(`GPT_OFS_CTRL1, 16'h0080);
      wr(`GPT_OFS_RELOAD, 16'h0001);
      wr(`GPT_OFS_CNT, 16'h0000);
      wr(`GPT_OFS_CTRL1, 16'h0081);
      tally(3, 0);
      check(16'(n), 16'h0000);
      repeat (6) @(posedge ref_clk_in);
      tally(16, 0);
      check(16'(n), 16'h0008);
      wr(`GPT_OFS_CTRL1, 16'h0009);
      repeat (8) @(posedge ref_clk_in);
      rd(`GPT_OFS_CTRL1);
      check(rv, 16'h0008);
      $display("test preload done");
      // update gating, request source and the interrupt
      wr(`GPT_OFS_IEN, 16'h0001);
      wr(`GPT_OFS_STAT, 16'h0001);
      wr(`GPT_OFS_CTRL1, 16'h0002);
      wr(`GPT_OFS_EVGEN, 16'h0001);
      #1 check(16'(update_event_out), 16'h0000);
      rd(`GPT_OFS_STAT);
      check(rv, 16'h0000);
      wr(`GPT_OFS_CTRL1, 16'h0004);
      wr(`GPT_OFS_EVGEN, 16'h0001);
      #1 check(16'(update_event_out), 16'h0001);
      rd(`GPT_OFS_STAT);
      check(rv, 16'h0000);
      wr(`GPT_OFS_CTRL1, 16'h0005);
      repeat (6) @(posedge ref_clk_in);
      wr(`GPT_OFS_CTRL1, 16'h0004);
      rd(`GPT_OFS_STAT);
      check(rv, 16'h0001);
      check(16'(irq_out), 16'h0001);
      wr(`GPT_OFS_IEN, 16'h0000);
      repeat (2) @(posedge ref_clk_in);
      #1 check(16'(irq_out), 16'h0000);
      wr(`GPT_OFS_IEN, 16'h0001);
      wr(`GPT_OFS_STAT, 16'h0001);
      repeat (2) @(posedge ref_clk_in);
      #1 check(16'(irq_out), 16'h0000);
      wr(`GPT_OFS_CTRL1, 16'h0000);
      @(posedge ref_clk_in);
      evt.slave_update <= 1'b1;
      @(posedge ref_clk_in);
      evt.slave_update <= 1'b0;
      #1 check(16'(update_event_out), 16'h0001);
      rd(`GPT_OFS_STAT);
      check(rv, 16'h0001);
      wr(`GPT_OFS_STAT, 16'h0001);
      $display("test update done");
      // trigger mode lets the trigger input start the counter
      wr(`GPT_OFS_SMODE, 16'h0006);
      @(posedge ref_clk_in);
      evt.trigger <= 1'b1;
      @(posedge ref_clk_in);
      evt.trigger <= 1'b0;
      rd(`GPT_OFS_CTRL1);
      check(rv, 16'h0001);
      wr(`GPT_OFS_SMODE, 16'h0000);
      for (int c = 0; c < 4; c++) begin
         wr(`GPT_OFS_CTRL1, 16'(c) << 8);
         repeat (6) @(posedge ref_clk_in);
         tally(16, 1);
         check(16'(n), 16'(dexp[c]));
      end
      $display("test trigger and divider done");
      give_verdict();
   end
endmodule
